// >>> shared/rsq_defines.svh
/*
  Constants of the reset sequencer: register indices and byte addresses,
  field positions, reset values and timing counts.
  Assumes a 50 MHz block clock; included by its bare name.
*/
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH

// block clock
`define RSQ_CLK_HZ 50000000
`define RSQ_CLK_PERIOD_NS 20

// low-frequency oscillator, made by dividing the block clock
`define RSQ_LF_OSC_HZ 31000
`define RSQ_LF_DIV_CYC (`RSQ_CLK_HZ / `RSQ_LF_OSC_HZ)

// power-up delay: 64 ms counted in low-frequency ticks
`define RSQ_POWER_UP_DELAY_TIMER_MS 64
`define RSQ_POWER_UP_DELAY_TIMER_TICKS (`RSQ_POWER_UP_DELAY_TIMER_MS * `RSQ_LF_OSC_HZ / 1000)

// oscillator start-up: 1024 main oscillator periods
`define RSQ_OST_PERIODS 11'h0400

// least brown-out duration, rounded up to whole cycles
`define RSQ_BROWNOUT_MIN_DURATION_NS 10000
`define RSQ_BROWNOUT_MIN_DURATION_CYC \
  ((`RSQ_BROWNOUT_MIN_DURATION_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)

// clear pin glitch filter, least pulse width rounded up
`define RSQ_MASTER_CLEAR_PIN_FILT_NS 2000
`define RSQ_MASTER_CLEAR_PIN_FILT_CYC \
  ((`RSQ_MASTER_CLEAR_PIN_FILT_NS + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)

// register indices; byte address is four times the index
`define RSQ_IDX_POWER_CONTROL_FLAGS 10'h08E
`define RSQ_IDX_CFG 10'h08F
`define RSQ_IDX_STAT 10'h090
`define RSQ_IDX_KEEP 10'h091
`define RSQ_ADDR_POWER_CONTROL_FLAGS {`RSQ_IDX_POWER_CONTROL_FLAGS, 2'b00}
`define RSQ_ADDR_CFG {`RSQ_IDX_CFG, 2'b00}
`define RSQ_ADDR_STAT {`RSQ_IDX_STAT, 2'b00}
`define RSQ_ADDR_KEEP {`RSQ_IDX_KEEP, 2'b00}

// power_control_flags fields
`define RSQ_POWER_CONTROL_FLAGS_BOR_N 0
`define RSQ_POWER_CONTROL_FLAGS_POR_N 1
`define RSQ_POWER_CONTROL_FLAGS_SOFT_BROWNOUT_ENABLE 4

// configuration register fields
`define RSQ_CFG_EXT_CLEAR_PIN_SELECT 0
`define RSQ_CFG_PWRTD 1
`define RSQ_CFG_BOREN_LO 2
`define RSQ_CFG_BOREN_HI 3
`define RSQ_CFG_BROWNOUT_LEVEL_SELECT 4
`define RSQ_CFG_OSC_LO 5
`define RSQ_CFG_OSC_HI 6

// status register fields
`define RSQ_STAT_PD 0
`define RSQ_STAT_TO 1
`define RSQ_STAT_CAUSE_LO 2
`define RSQ_STAT_CAUSE_HI 4
`define RSQ_STAT_STATE_LO 5
`define RSQ_STAT_STATE_HI 7

// reset values
`define RSQ_CFG_RESET 8'h0D
`define RSQ_POWER_CONTROL_FLAGS_RESET 8'h03

`endif

// >>> shared/rsq_pkg.sv
/*
  Types of the reset sequencer: states, causes, modes and the state record.
  Assumes the constants header for widths of counters.
*/
package rsq_pkg;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_POWER_UP_DELAY_TIMER = 3'b001,
    ST_OST = 3'b010,
    ST_RUN = 3'b011
  } rsq_state_e;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'b000,
    CAUSE_POR = 3'b001,
    CAUSE_WDT_RUN = 3'b010,
    CAUSE_WDT_SLEEP = 3'b011,
    CAUSE_MASTER_CLEAR_PIN_RUN = 3'b100,
    CAUSE_MASTER_CLEAR_PIN_SLEEP = 3'b101,
    CAUSE_BOR = 3'b110
  } rsq_cause_e;

  typedef enum logic [1:0] {
    BOR_OFF = 2'b00,
    BOR_SOFT = 2'b01,
    BOR_AWAKE = 2'b10,
    BOR_ALWAYS = 2'b11
  } rsq_bor_mode_e;

  typedef enum logic [1:0] {
    OSC_CRYSTAL = 2'b00,
    OSC_EXT_CLOCK = 2'b01,
    OSC_RC = 2'b10,
    OSC_INTERNAL = 2'b11
  } rsq_osc_mode_e;

  typedef struct packed {
    rsq_osc_mode_e osc_mode;
    logic brownout_level_select;
    rsq_bor_mode_e brownout_mode_select;
    logic power_up_delay_disable;
    logic ext_clear_pin_select;
  } rsq_cfg_s;

  typedef struct packed {
    rsq_state_e state;
    rsq_cause_e cause;
    rsq_cfg_s cfg;
    logic power_up_delay_timer_need;
    logic ost_need;
    logic wake_ost;
    logic [10:0] lf_div;
    logic [10:0] tcnt;
    logic [9:0] bor_cnt;
    logic [6:0] master_clear_pin_cnt;
    logic master_clear_pin_act;
    logic por_n;
    logic bor_n;
    logic soft_brownout_enable;
    logic timeout_flag;
    logic powered_down_flag;
    logic [7:0] keep;
    logic core_hold;
    logic reg_init;
    logic wake;
    logic bor_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rsq_regs_s;

endpackage

// >>> rtl/rsq_top.sv
/*
  Reset sequencer: reset causes, power-up delay, oscillator start-up
  count, brown-out qualification, clear pin filter and cause flags,
  with an APB slave for its registers.
  Assumes all inputs synchronous to mclk_in; the supply monitor reports
  the threshold picked by brownout_level_select; osc_tick_in pulses once
  per main oscillator period.
*/
// Contract
// - tell apart six reset causes
// - registers reset except on watchdog wake-up
// - some registers kept through every reset
// - timeout and powered-down flags follow cause
// - clear pin glitches filtered out
// - watchdog reset never drives clear pin
// - select 0 internal clear, 1 pin with pull-up
// - 64 ms delay after power-on/brown-out only
// - delay disable bit turns timer off
// - mode 01 uses software brown-out enable
// - mode 10 off in sleep, on awake
// - level select reported to supply monitor
// - dips past minimum duration cause reset
// - hold until supply above threshold, then delay
// - dip during delay restarts full delay
// - order: power-on, delay, oscillator start-up
// - crystal mode adds 1024 oscillator periods
// - other clock modes: no start-up count
// - time-outs run regardless of clear pin
// - bit 0 brown-out flag, cleared on brown-out
// - bit 1 power-on flag, cleared on power-on
// - flag values per reset cause
`timescale 1ns/1ps
`include "rsq_defines.svh"

module rsq_top
#(
  parameter logic [10:0] POWER_UP_DELAY_TIMER_TICKS = 11'(`RSQ_POWER_UP_DELAY_TIMER_TICKS),
  parameter logic [10:0] LF_DIV = 11'(`RSQ_LF_DIV_CYC)
)
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  input wire logic por_detect_in,
  input wire logic supply_low_in,
  input wire logic sleep_in,
  input wire logic watchdog_reset_in,
  input wire logic osc_tick_in,
  input wire logic master_clear_pin_in,
  output logic master_clear_pin_out,
  output logic master_clear_pin_oe_out,
  output logic master_clear_pullup_out,
  output logic brownout_level_select_out,
  output logic brownout_enable_out,
  output logic core_hold_out,
  output logic reg_init_out,
  output logic wake_out
);

  localparam logic [9:0] BROWNOUT_MIN_DURATION_CYC = 10'(`RSQ_BROWNOUT_MIN_DURATION_CYC);
  localparam logic [6:0] FILT_CYC = 7'(`RSQ_MASTER_CLEAR_PIN_FILT_CYC);
  localparam logic [10:0] OST_CYC = `RSQ_OST_PERIODS;

  localparam rsq_pkg::rsq_regs_s REGS_RESET = '{
    state: rsq_pkg::ST_HOLD,
    cause: rsq_pkg::CAUSE_NONE,
    cfg: rsq_pkg::rsq_cfg_s'(7'(`RSQ_CFG_RESET)),
    power_up_delay_timer_need: 1'b1,
    ost_need: 1'b1,
    wake_ost: 1'b0,
    lf_div: 11'h000,
    tcnt: 11'h000,
    bor_cnt: 10'h000,
    master_clear_pin_cnt: 7'h00,
    master_clear_pin_act: 1'b0,
    por_n: 1'(`RSQ_POWER_CONTROL_FLAGS_RESET >> `RSQ_POWER_CONTROL_FLAGS_POR_N),
    bor_n: 1'(`RSQ_POWER_CONTROL_FLAGS_RESET >> `RSQ_POWER_CONTROL_FLAGS_BOR_N),
    soft_brownout_enable: 1'b0,
    timeout_flag: 1'b1,
    powered_down_flag: 1'b1,
    keep: 8'h00,
    core_hold: 1'b1,
    reg_init: 1'b1,
    wake: 1'b0,
    bor_en: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  rsq_pkg::rsq_regs_s s_ff;
  rsq_pkg::rsq_regs_s nxt_s;

  logic lf_tick;
  logic bor_on;
  logic bor_trip;
  logic pin_low;
  logic master_clear_pin_event;
  logic crystal;
  logic access;
  logic complete;
  logic addr_ok;
  logic [31:0] rd_word;
  rsq_pkg::rsq_state_e after_power_up_delay_timer;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.wake = 1'b0;
    crystal = (s_ff.cfg.osc_mode == rsq_pkg::OSC_CRYSTAL);

    // register slave: answer one cycle into the access phase
    access = psel_in & penable_in;
    complete = access & s_ff.pready;
    addr_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr_in)
      `RSQ_ADDR_POWER_CONTROL_FLAGS:
      begin
        rd_word[`RSQ_POWER_CONTROL_FLAGS_BOR_N] = s_ff.bor_n;
        rd_word[`RSQ_POWER_CONTROL_FLAGS_POR_N] = s_ff.por_n;
        rd_word[`RSQ_POWER_CONTROL_FLAGS_SOFT_BROWNOUT_ENABLE] = s_ff.soft_brownout_enable;
      end
      `RSQ_ADDR_CFG:
        rd_word[6:0] = s_ff.cfg;
      `RSQ_ADDR_STAT:
      begin
        rd_word[`RSQ_STAT_PD] = s_ff.powered_down_flag;
        rd_word[`RSQ_STAT_TO] = s_ff.timeout_flag;
        rd_word[`RSQ_STAT_CAUSE_HI:`RSQ_STAT_CAUSE_LO] = s_ff.cause;
        rd_word[`RSQ_STAT_STATE_HI:`RSQ_STAT_STATE_LO] = s_ff.state;
      end
      `RSQ_ADDR_KEEP:
        rd_word[7:0] = s_ff.keep;
      default:
        addr_ok = 1'b0;
    endcase
    nxt_s.pready = access & ~s_ff.pready;
    // error stands only alongside ready, never after it
    nxt_s.pslverr = access & ~s_ff.pready & ~addr_ok;
    if (access & ~s_ff.pready)
    begin
      nxt_s.prdata = pwrite_in ? 32'h0000_0000 : rd_word;
    end
    if (complete & pwrite_in & pstrb_in[0] & addr_ok)
    begin
      case (paddr_in)
        `RSQ_ADDR_POWER_CONTROL_FLAGS:
        begin
          nxt_s.bor_n = pwdata_in[`RSQ_POWER_CONTROL_FLAGS_BOR_N];
          nxt_s.por_n = pwdata_in[`RSQ_POWER_CONTROL_FLAGS_POR_N];
          nxt_s.soft_brownout_enable = pwdata_in[`RSQ_POWER_CONTROL_FLAGS_SOFT_BROWNOUT_ENABLE];
        end
        `RSQ_ADDR_CFG:
          nxt_s.cfg = rsq_pkg::rsq_cfg_s'(pwdata_in[6:0]);
        `RSQ_ADDR_KEEP:
          nxt_s.keep = pwdata_in[7:0];
        default:
          nxt_s.keep = s_ff.keep;
      endcase
    end

    // low-frequency tick from the block clock
    lf_tick = (s_ff.lf_div == LF_DIV - 11'h001);
    nxt_s.lf_div = lf_tick ? 11'h000 : s_ff.lf_div + 11'h001;

    // brown-out enable by mode
    case (s_ff.cfg.brownout_mode_select)
      rsq_pkg::BOR_SOFT:
        bor_on = s_ff.soft_brownout_enable;
      rsq_pkg::BOR_AWAKE:
        bor_on = ~sleep_in;
      rsq_pkg::BOR_ALWAYS:
        bor_on = 1'b1;
      default:
        bor_on = 1'b0;
    endcase
    nxt_s.bor_en = bor_on;

    // dip must outlast the least brown-out duration
    if (bor_on & supply_low_in)
    begin
      if (s_ff.bor_cnt != BROWNOUT_MIN_DURATION_CYC)
        nxt_s.bor_cnt = s_ff.bor_cnt + 10'h001;
    end
    else
      nxt_s.bor_cnt = 10'h000;
    bor_trip = bor_on & supply_low_in & (s_ff.bor_cnt == BROWNOUT_MIN_DURATION_CYC);

    // symmetric filter: a level must hold FILT_CYC cycles to count
    pin_low = s_ff.cfg.ext_clear_pin_select & ~master_clear_pin_in;
    if (pin_low == s_ff.master_clear_pin_act)
      nxt_s.master_clear_pin_cnt = 7'h00;
    else if (s_ff.master_clear_pin_cnt == FILT_CYC - 7'h01)
    begin
      nxt_s.master_clear_pin_cnt = 7'h00;
      nxt_s.master_clear_pin_act = pin_low;
    end
    else
      nxt_s.master_clear_pin_cnt = s_ff.master_clear_pin_cnt + 7'h01;
    master_clear_pin_event = nxt_s.master_clear_pin_act & ~s_ff.master_clear_pin_act;

    after_power_up_delay_timer = crystal ? rsq_pkg::ST_OST : rsq_pkg::ST_RUN;

    // causes in priority order; a hardware event wins over a write
    if (por_detect_in)
    begin
      nxt_s.state = rsq_pkg::ST_HOLD;
      nxt_s.cause = rsq_pkg::CAUSE_POR;
      nxt_s.por_n = 1'b0;
      nxt_s.timeout_flag = 1'b1;
      nxt_s.powered_down_flag = 1'b1;
      nxt_s.power_up_delay_timer_need = 1'b1;
      nxt_s.ost_need = 1'b1;
      nxt_s.wake_ost = 1'b0;
      nxt_s.tcnt = 11'h000;
    end
    else if (bor_trip ||
             (s_ff.state == rsq_pkg::ST_POWER_UP_DELAY_TIMER && bor_on && supply_low_in))
    begin
      nxt_s.state = rsq_pkg::ST_HOLD;
      nxt_s.cause = rsq_pkg::CAUSE_BOR;
      nxt_s.bor_n = 1'b0;
      nxt_s.timeout_flag = 1'b1;
      nxt_s.powered_down_flag = 1'b1;
      nxt_s.power_up_delay_timer_need = 1'b1;
      nxt_s.ost_need = 1'b1;
      nxt_s.wake_ost = 1'b0;
      nxt_s.tcnt = 11'h000;
    end
    else if (watchdog_reset_in && s_ff.state == rsq_pkg::ST_RUN)
    begin
      nxt_s.timeout_flag = 1'b0;
      nxt_s.tcnt = 11'h000;
      if (sleep_in)
      begin
        // wake-up resumes; registers are left alone
        nxt_s.cause = rsq_pkg::CAUSE_WDT_SLEEP;
        nxt_s.powered_down_flag = 1'b0;
        nxt_s.wake = 1'b1;
        nxt_s.wake_ost = crystal;
        nxt_s.state = crystal ? rsq_pkg::ST_OST : rsq_pkg::ST_RUN;
      end
      else
      begin
        nxt_s.cause = rsq_pkg::CAUSE_WDT_RUN;
        nxt_s.state = rsq_pkg::ST_HOLD;
        nxt_s.power_up_delay_timer_need = 1'b0;
        nxt_s.ost_need = 1'b0;
      end
    end
    else
    begin
      case (s_ff.state)
        rsq_pkg::ST_HOLD:
        begin
          nxt_s.tcnt = 11'h000;
          if (!(bor_on && supply_low_in))
          begin
            if (s_ff.power_up_delay_timer_need && !s_ff.cfg.power_up_delay_disable)
              nxt_s.state = rsq_pkg::ST_POWER_UP_DELAY_TIMER;
            else if (s_ff.ost_need && crystal)
              nxt_s.state = rsq_pkg::ST_OST;
            else
              nxt_s.state = rsq_pkg::ST_RUN;
          end
        end
        rsq_pkg::ST_POWER_UP_DELAY_TIMER:
        begin
          if (lf_tick)
          begin
            if (s_ff.tcnt == POWER_UP_DELAY_TIMER_TICKS - 11'h001)
            begin
              nxt_s.tcnt = 11'h000;
              nxt_s.state = after_power_up_delay_timer;
            end
            else
              nxt_s.tcnt = s_ff.tcnt + 11'h001;
          end
        end
        rsq_pkg::ST_OST:
        begin
          if (osc_tick_in)
          begin
            if (s_ff.tcnt == OST_CYC - 11'h001)
            begin
              nxt_s.tcnt = 11'h000;
              nxt_s.state = rsq_pkg::ST_RUN;
            end
            else
              nxt_s.tcnt = s_ff.tcnt + 11'h001;
          end
        end
        rsq_pkg::ST_RUN:
        begin
          nxt_s.power_up_delay_timer_need = 1'b0;
          nxt_s.ost_need = 1'b0;
          nxt_s.wake_ost = 1'b0;
        end
        default:
          nxt_s.state = rsq_pkg::ST_HOLD;
      endcase

      // clear pin only gates release; time-outs keep running
      if (master_clear_pin_event)
      begin
        if (sleep_in)
        begin
          nxt_s.cause = rsq_pkg::CAUSE_MASTER_CLEAR_PIN_SLEEP;
          nxt_s.timeout_flag = 1'b1;
          nxt_s.powered_down_flag = 1'b0;
        end
        else
          nxt_s.cause = rsq_pkg::CAUSE_MASTER_CLEAR_PIN_RUN;
      end
    end

    // release as soon as sequence done and pin high
    nxt_s.core_hold = (nxt_s.state != rsq_pkg::ST_RUN) |
                      nxt_s.master_clear_pin_act;
    nxt_s.reg_init = ((nxt_s.state != rsq_pkg::ST_RUN) & ~nxt_s.wake_ost) |
                     nxt_s.master_clear_pin_act;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      s_ff <= REGS_RESET;
    else
      s_ff <= nxt_s;
  end

  assign pready_out = s_ff.pready;
  assign pslverr_out = s_ff.pslverr;
  assign prdata_out = s_ff.prdata;
  // the pin is an input only; no reset cause ever drives it low
  assign master_clear_pin_out = 1'b0;
  assign master_clear_pin_oe_out = 1'b0;
  assign master_clear_pullup_out = s_ff.cfg.ext_clear_pin_select;
  assign brownout_level_select_out =
    s_ff.cfg.brownout_level_select;
  assign brownout_enable_out = s_ff.bor_en;
  assign core_hold_out = s_ff.core_hold;
  assign reg_init_out = s_ff.reg_init;
  assign wake_out = s_ff.wake;

endmodule

// >>> dv/rsq_assertions.sv
/* Port checker of the reset sequencer, bound into rsq_top.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module rsq_assertions (
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic por_detect_in,
  input wire logic supply_low_in,
  input wire logic sleep_in,
  input wire logic watchdog_reset_in,
  input wire logic master_clear_pin_in,
  input wire logic master_clear_pin_out,
  input wire logic master_clear_pin_oe_out,
  input wire logic core_hold_out,
  input wire logic reg_init_out,
  input wire logic wake_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  sequence s_access;
    psel_in && $rose(penable_in);
  endsequence
  sequence s_run;
    !core_hold_out && !por_detect_in && !supply_low_in;
  endsequence
  AST_PIN_UNDRIVEN: assert property (
    !master_clear_pin_oe_out && !master_clear_pin_out)
    else $error("clear pin driven");
  AST_READY_AFTER_ACCESS: assert property (s_access |=> pready_out)
    else $error("ready late");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  AST_ERR_WITH_READY: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  AST_POR_HOLDS: assert property (
    por_detect_in |-> ##[1:2] (core_hold_out && reg_init_out))
    else $error("power-on not held");
  AST_DELAY_HOLDS: assert property (
    $fell(por_detect_in) |-> core_hold_out [*8])
    else $error("released before delay");
  AST_RELEASE_SUPPLY_OK: assert property (
    $fell(core_hold_out) |-> !por_detect_in && !supply_low_in)
    else $error("released with low supply");
  AST_WDT_RESETS: assert property (
    s_run ##0 (watchdog_reset_in && !sleep_in) |-> ##[1:3] reg_init_out)
    else $error("watchdog reset lost");
  AST_WAKE_KEEPS_REGS: assert property (wake_out |-> !reg_init_out)
    else $error("wake-up reset registers");
  AST_GLITCH_IGNORED: assert property (
    !core_hold_out && $fell(master_clear_pin_in) |-> !core_hold_out [*8])
    else $error("clear glitch reset core");
endmodule
bind rsq_top rsq_assertions u_chk (.mclk_in, .srst_in, .psel_in,
  .penable_in, .pready_out, .pslverr_out, .por_detect_in, .supply_low_in,
  .sleep_in, .watchdog_reset_in, .master_clear_pin_in,
  .master_clear_pin_out, .master_clear_pin_oe_out, .core_hold_out,
  .reg_init_out, .wake_out);

// >>> dv/rsq_partner.sv
/* Far side model: supply monitor, clear pin wire, main oscillator.
   Assumes the bench sets the supply in millivolts. */
`timescale 1ns/1ps
module rsq_partner (
  input wire logic mclk_in,
  input wire logic [12:0] vdd_mv_in,
  input wire logic ext_low_in,
  input wire logic level_in,
  input wire logic pullup_in,
  input wire logic pin_oe_in,
  input wire logic pin_drv_in,
  output logic por_detect_out,
  output logic supply_low_out,
  output logic osc_tick_out,
  output logic pin_level_out
);
  logic tick_ff = 1'b0;
  always_ff @(posedge mclk_in)
    tick_ff <= !tick_ff;
  assign osc_tick_out = tick_ff;
  assign por_detect_out = vdd_mv_in < 13'h05DC;
  // threshold follows the level the device reports
  assign supply_low_out =
    vdd_mv_in < (level_in ? 13'h0FA0 : 13'h0834);
  // floating wire toggles so a stale level never reads as valid
  assign pin_level_out = pin_oe_in ? pin_drv_in : ext_low_in ? 1'b0 :
    pullup_in ? 1'b1 : tick_ff;
endmodule

// >>> dv/test_rsq_top.sv
/* Self-checking bench of the reset sequencer over APB.
   Assumes the partner model for supply, clear pin and oscillator. */
`timescale 1ns/1ps
`include "rsq_defines.svh"
module test_rsq_top;
  localparam int PT = 16;
  localparam int OSC_STARTUP_COUNTER = 2048;
  localparam logic [11:0] AP = `RSQ_ADDR_POWER_CONTROL_FLAGS;
  localparam logic [11:0] AC = `RSQ_ADDR_CFG;
  localparam logic [11:0] AS = `RSQ_ADDR_STAT;
  logic mclk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [3:0] pstrb_in = 4'h1;
  logic sleep_in = 1'b0;
  logic watchdog_reset_in = 1'b0;
  logic ext_low = 1'b1;
  logic [12:0] vdd = 13'h0000;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, master_clear_pin_out, perr;
  logic master_clear_pin_oe_out, master_clear_pullup_out, wake_out;
  logic brownout_level_select_out, brownout_enable_out, core_hold_out;
  logic reg_init_out, por_detect_in, supply_low_in, osc_tick_in;
  logic master_clear_pin_in;
  int err_total = 0;
  int comparisons = 0;
  int wakes = 0;
  int n;
  initial
  begin
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
    if (wake_out === 1'b1) wakes++;
  rsq_top #(.POWER_UP_DELAY_TIMER_TICKS(11'h004), .LF_DIV(11'h004)) DUT (.mclk_in,
    .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .pstrb_in, .pready_out, .pslverr_out, .prdata_out, .por_detect_in,
    .supply_low_in, .sleep_in, .watchdog_reset_in, .osc_tick_in,
    .master_clear_pin_in, .master_clear_pin_out, .master_clear_pin_oe_out,
    .master_clear_pullup_out, .brownout_level_select_out,
    .brownout_enable_out, .core_hold_out, .reg_init_out, .wake_out);
  rsq_partner u_far (.mclk_in, .vdd_mv_in(vdd), .ext_low_in(ext_low),
    .level_in(brownout_level_select_out),
    .pullup_in(master_clear_pullup_out),
    .pin_oe_in(master_clear_pin_oe_out), .pin_drv_in(master_clear_pin_out),
    .por_detect_out(por_detect_in), .supply_low_out(supply_low_in),
    .osc_tick_out(osc_tick_in), .pin_level_out(master_clear_pin_in));
  task automatic complete_run;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h00_0000, d};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    q = prdata_out[7:0];
    perr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1)
    begin
      err_total++;
      complete_run();
    end
    @(posedge mclk_in);
  endtask
  task automatic rd(input string nm, input logic [11:0] a,
    input logic [7:0] m, e);
    logic [7:0] q;
    apb(1'b0, a, 8'h00, q);
    chk(nm, q & m, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic wt(input logic v, input int m);
    n = 0;
    while (core_hold_out !== v && n < m)
    begin
      @(posedge mclk_in);
      n++;
    end
    if (core_hold_out !== v)
    begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic pulse_wdt(input logic s);
    sleep_in <= s;
    cyc(2);
    watchdog_reset_in <= 1'b1;
    @(posedge mclk_in);
    watchdog_reset_in <= 1'b0;
    cyc(3);
    sleep_in <= 1'b0;
  endtask
  task automatic pin(input int k);
    ext_low <= 1'b1;
    cyc(k);
    ext_low <= 1'b0;
  endtask
  initial
  begin
    cyc(6);
    srst_in <= 1'b0;
    cyc(10);
    rd("cfg reset", AC, 8'hFF, 8'h0D);
    vdd <= 13'h1388;
    cyc(PT + OSC_STARTUP_COUNTER + 100);
    chk("held by pin", core_hold_out, 1'b1);
    ext_low <= 1'b0;
    wt(1'b0, 120);
    rd("flags", AS, 8'hE3, 8'h63);
    wr(AP, 8'h03);
    wr(`RSQ_ADDR_KEEP, 8'hA5);
    $display("test power-up done");
    vdd <= 13'h0000;
    cyc(20);
    vdd <= 13'h1388;
    wt(1'b0, PT + OSC_STARTUP_COUNTER + 40);
    chk("delay length", n >= PT + OSC_STARTUP_COUNTER - 4, 1'b1);
    rd("cause por", AS, 8'hFF, 8'h67);
    rd("por flag", AP, 8'h02, 8'h00);
    rd("keep", `RSQ_ADDR_KEEP, 8'hFF, 8'hA5);
    pstrb_in <= 4'h0;
    wr(`RSQ_ADDR_KEEP, 8'h5A);
    pstrb_in <= 4'h1;
    rd("strobe off", `RSQ_ADDR_KEEP, 8'hFF, 8'hA5);
    rd("unmapped", 12'h300, 8'hFF, 8'h00);
    chk("slverr", perr, 1'b1);
    wr(AP, 8'h03);
    pulse_wdt(1'b0);
    wt(1'b0, 20);
    rd("cause wdt", AS, 8'hFF, 8'h69);
    rd("flags kept", AP, 8'h03, 8'h03);
    pulse_wdt(1'b1);
    chk("wake", wakes, 1);
    wt(1'b0, OSC_STARTUP_COUNTER + 40);
    chk("wake startup", n > OSC_STARTUP_COUNTER - 60, 1'b1);
    rd("cause wake", AS, 8'hFF, 8'h6C);
    wr(AC, 8'h6D);
    pulse_wdt(1'b1);
    wt(1'b0, 10);
    chk("wake internal", wakes, 2);
    wr(AC, 8'h0D);
    $display("test watchdog done");
    pin(50);
    cyc(5);
    chk("glitch", core_hold_out, 1'b0);
    pin(150);
    cyc(2);
    wt(1'b0, OSC_STARTUP_COUNTER + 200);
    rd("cause pin", AS, 8'hFF, 8'h70);
    sleep_in <= 1'b1;
    pin(150);
    sleep_in <= 1'b0;
    cyc(2);
    wt(1'b0, OSC_STARTUP_COUNTER + 200);
    rd("cause pin sleep", AS, 8'hFF, 8'h76);
    wr(AC, 8'h0C);
    cyc(2);
    chk("pullup off", master_clear_pullup_out, 1'b0);
    pin(150);
    cyc(2);
    chk("pin ignored", core_hold_out, 1'b0);
    wr(AC, 8'h0D);
    cyc(2);
    chk("pullup on", master_clear_pullup_out, 1'b1);
    $display("test clear pin done");
    vdd <= 13'h0708;
    cyc(100);
    vdd <= 13'h1388;
    cyc(5);
    chk("short dip", core_hold_out, 1'b0);
    vdd <= 13'h0708;
    cyc(600);
    chk("bor hold", core_hold_out, 1'b1);
    vdd <= 13'h1388;
    cyc(PT - 4);
    vdd <= 13'h0708;
    cyc(3);
    vdd <= 13'h1388;
    wt(1'b0, PT + OSC_STARTUP_COUNTER + 40);
    chk("delay restart", n >= PT + OSC_STARTUP_COUNTER - 4, 1'b1);
    rd("cause bor", AS, 8'hFF, 8'h7B);
    rd("bor flag", AP, 8'h01, 8'h00);
    wr(AC, 8'h0F);
    vdd <= 13'h0000;
    cyc(20);
    vdd <= 13'h1388;
    wt(1'b0, OSC_STARTUP_COUNTER + 40);
    chk("delay off", n >= OSC_STARTUP_COUNTER - 4 && n <= OSC_STARTUP_COUNTER + 8, 1'b1);
    wr(AC, 8'h0D);
    $display("test brown-out done");
    wr(AP, 8'h13);
    for (int m = 0; m < 4; m++)
      for (int s = 0; s < 2; s++)
      begin
        wr(AC, 8'(1 + 4 * m));
        sleep_in <= s[0];
        cyc(3);
        chk("bor enable", brownout_enable_out,
          m == 3 || m == 1 || (m == 2 && s == 0));
        sleep_in <= 1'b0;
      end
    wr(AP, 8'h03);
    wr(AC, 8'h05);
    cyc(3);
    chk("soft off", brownout_enable_out, 1'b0);
    wr(AC, 8'h1D);
    cyc(3);
    chk("level high", brownout_level_select_out, 1'b1);
    $display("test modes done");
    complete_run();
  end
endmodule
